// ==== hw/four_port_parallel_io_defs.svh ====
// Reset values, pin positions and timing counts for the parallel port block.
`ifndef FOUR_PORT_PARALLEL_IO_DEFS_SVH
`define FOUR_PORT_PARALLEL_IO_DEFS_SVH

`define PORT_ZERO_RESET 8'h_ff
`define PORT_ONE_RESET 8'h_ff
`define PORT_TWO_RESET 8'h_ff
`define PORT_THREE_RESET 8'h_ff
`define CLK_PERIOD_NS 10
`define GLITCH_REJECT_NS 50
// Glitches up to the reject time are absorbed: a level must hold for one cycle more.
`define GLITCH_CYCLES ((`GLITCH_REJECT_NS / `CLK_PERIOD_NS) + 1)
`define GLITCH_CNT_W 3
`define P1_T2_BIT 0
`define P1_TIMER2_CAPTURE_TRIGGER_BIT 1
`define P1_SS_BIT 5
`define P2_PWM0_BIT 6
`define P2_PWM1_BIT 7
`define P3_RXD_BIT 0
`define P3_TXD_BIT 1
`define P3_IRQ0_BIT 2
`define P3_IRQ1_BIT 3
`define P3_T0_BIT 4
`define P3_T1_BIT 5
`define P3_WR_BIT 6
`define P3_RD_BIT 7

`endif

// ==== hw/four_port_parallel_io_pkg.sv ====
// Types shared by the parallel port block.
package four_port_parallel_io_pkg;
    typedef logic [7:0] port_byte_t;
    typedef enum logic [1:0] {
        PORT_SEL_ZERO = 2'h0,
        PORT_SEL_ONE = 2'h1,
        PORT_SEL_TWO = 2'h2,
        PORT_SEL_THREE = 2'h3
    } port_sel_t;
endpackage

// ==== hw/glitch_filter.sv ====
// Two-flop synchroniser followed by a stable-level glitch filter.
`timescale 1ns/1ps
`include "four_port_parallel_io_defs.svh"
module glitch_filter (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_level,
    output logic o_level
);
    logic sync1_reg;
    logic sync2_reg;
    logic [`GLITCH_CNT_W-1:0] count_reg;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
        end else begin
            sync1_reg <= i_level;
            sync2_reg <= sync1_reg;
        end
    end

    // The output only follows a level that has stood past the reject time.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count_reg <= '0;
            o_level <= 1'b1;
        end else if (sync2_reg == o_level) begin
            count_reg <= '0;
        end else if (count_reg == `GLITCH_CNT_W'(`GLITCH_CYCLES - 1)) begin
            count_reg <= '0;
            o_level <= sync2_reg;
        end else begin
            count_reg <= count_reg + `GLITCH_CNT_W'(1);
        end
    end
endmodule

// ==== hw/four_port_parallel_io.sv ====
// Four 8-bit parallel ports with latches, pin readback and alternate functions.
`timescale 1ns/1ps
`include "four_port_parallel_io_defs.svh"

// What this block does
// - Latch per bit; latch or pin readback
// - External access forces port zero latches high
// - External access drives port zero push-pull
// - Port zero: one floats, zero drives low
// - Port one is input only
// - Port one resets high, analog selected
// - Port one feeds timer2 and SPI select
// - Port two carries high address bytes
// - Port two driven externally, latch unchanged
// - Port two: one pulled up, zero low
// - PWM overrides port two bits six, seven
// - Port three is quasi-bidirectional
// - Port three alternates need latch one
// - Port three alternate function pin order
// - PWM overrides port three bits three, four
// - Serial pins: weak pull-up or push-pull
// - Two-wire inputs filtered against 50 ns
// - Software drives serial pins in master mode
// - Enabled peripheral takes over its pin
// - Read-modify-write reads latch, not pin
module four_port_parallel_io (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_latch_write,
    input wire logic i_latch_read,
    input wire logic i_pin_read,
    input wire logic i_rmw_bit,
    input wire logic [2:0] i_bit_index,
    input wire logic i_bit_value,
    input wire logic [1:0] i_port_sel,
    input wire logic [7:0] i_write_data,
    output logic [7:0] o_read_data,
    input wire logic i_ext_access,
    input wire logic i_ext_data_space,
    input wire logic [7:0] i_ext_addr_data,
    input wire logic [7:0] i_ext_addr_high,
    input wire logic [7:0] i_ext_addr_mid,
    input wire logic i_ext_write_strobe_n,
    input wire logic i_ext_read_strobe_n,
    input wire logic [7:0] i_port_zero_pin,
    output logic [7:0] o_port_zero_out,
    output logic [7:0] o_port_zero_oe,
    input wire logic [7:0] i_port_one_pin,
    output logic [7:0] o_port_one_digital_en,
    output logic o_timer2_count_input,
    output logic o_timer2_capture_trigger,
    output logic o_spi_slave_select_n,
    input wire logic [7:0] i_port_two_pin,
    output logic [7:0] o_port_two_out,
    output logic [7:0] o_port_two_oe,
    output logic [7:0] o_port_two_pullup,
    input wire logic [7:0] i_port_three_pin,
    output logic [7:0] o_port_three_out,
    output logic [7:0] o_port_three_oe,
    output logic [7:0] o_port_three_pullup,
    input wire logic i_uart_txd,
    input wire logic i_uart_mode0_data_oe,
    input wire logic i_uart_mode0_data,
    input wire logic i_miso_oe,
    input wire logic i_miso,
    output logic o_uart_rxd,
    output logic o_external_irq_zero,
    output logic o_external_irq_one,
    output logic o_timer_zero_count_input,
    output logic o_timer_one_count_input,
    input wire logic i_pwm_on_port_two,
    input wire logic i_pwm_on_port_three,
    input wire logic [1:0] i_pwm_out,
    input wire logic i_spi_mode_select,
    input wire logic i_spi_clock_oe,
    input wire logic i_spi_clock,
    input wire logic i_spi_data_oe,
    input wire logic i_spi_data,
    input wire logic i_twi_clock_low,
    input wire logic i_twi_data_low,
    input wire logic i_twi_direct_en,
    input wire logic i_twi_direct_clock,
    input wire logic i_twi_direct_data,
    input wire logic i_serial_clock_pin,
    input wire logic i_serial_data_pin,
    output logic o_serial_clock_pin_out,
    output logic o_serial_clock_pin_oe,
    output logic o_serial_clock_strong,
    output logic o_serial_data_pin_out,
    output logic o_serial_data_pin_oe,
    output logic o_serial_data_strong,
    output logic o_serial_clock_spi,
    output logic o_serial_data_spi,
    output logic o_serial_clock_twi,
    output logic o_serial_data_twi
);
    four_port_parallel_io_pkg::port_byte_t latch_reg [4];
    four_port_parallel_io_pkg::port_byte_t pin_sync1_reg [4];
    four_port_parallel_io_pkg::port_byte_t pin_sync2_reg [4];
    logic [1:0] sclk_sync_reg;
    logic [1:0] sdat_sync_reg;
    logic sclk_filt;
    logic sdat_filt;
    logic [7:0] p0_out_next;
    logic [7:0] p0_oe_next;
    logic [7:0] p2_out_next;
    logic [7:0] p2_oe_next;
    logic [7:0] p3_out_next;
    logic [7:0] p3_oe_next;
    logic [7:0] p3_alt_drive;
    logic [7:0] p3_alt_level;
    logic [7:0] rmw_value;

    function automatic logic [7:0] set_bit(input logic [7:0] value, input logic [2:0] idx, input logic bitv);
        logic [7:0] result;
        result = value;
        result[idx] = bitv;
        return result;
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Pins are asynchronous, so every pin read and decoded input comes from the second flop.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int p = 0; p < 4; p++) begin
                pin_sync1_reg[p] <= 8'h_ff;
                pin_sync2_reg[p] <= 8'h_ff;
            end
        end else begin
            pin_sync1_reg[0] <= i_port_zero_pin;
            pin_sync1_reg[1] <= i_port_one_pin;
            pin_sync1_reg[2] <= i_port_two_pin;
            pin_sync1_reg[3] <= i_port_three_pin;
            for (int p = 0; p < 4; p++) begin
                pin_sync2_reg[p] <= pin_sync1_reg[p];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sclk_sync_reg <= 2'h_3;
            sdat_sync_reg <= 2'h_3;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[0], i_serial_clock_pin};
            sdat_sync_reg <= {sdat_sync_reg[0], i_serial_data_pin};
        end
    end

    // ----------------------------------------
    // Bit latches
    // ----------------------------------------
    assign rmw_value = set_bit(latch_reg[i_port_sel], i_bit_index, i_bit_value);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            latch_reg[0] <= `PORT_ZERO_RESET;
            latch_reg[1] <= `PORT_ONE_RESET;
            latch_reg[2] <= `PORT_TWO_RESET;
            latch_reg[3] <= `PORT_THREE_RESET;
        end else begin
            if (i_rmw_bit) begin
                latch_reg[i_port_sel] <= rmw_value;
            end else if (i_latch_write) begin
                latch_reg[i_port_sel] <= i_write_data;
            end
            // The external bus owns port zero, so its latch is refilled with ones. Port two is left alone.
            if (i_ext_access) begin
                latch_reg[0] <= 8'h_ff;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_read_data <= 8'h_00;
        end else if (i_latch_read) begin
            o_read_data <= latch_reg[i_port_sel];
        end else if (i_pin_read) begin
            o_read_data <= pin_sync2_reg[i_port_sel];
        end
    end

    // ----------------------------------------
    // Port drive
    // ----------------------------------------
    always_comb begin
        if (i_ext_access) begin
            p0_out_next = i_ext_addr_data;
            p0_oe_next = 8'h_ff;
            p2_out_next = i_ext_data_space ? i_ext_addr_mid : i_ext_addr_high;
            p2_oe_next = 8'h_ff;
        end else begin
            p0_out_next = 8'h_00;
            p0_oe_next = ~latch_reg[0];
            p2_out_next = 8'h_00;
            p2_oe_next = ~latch_reg[2];
            if (i_pwm_on_port_two) begin
                p2_out_next[`P2_PWM0_BIT] = i_pwm_out[0];
                p2_out_next[`P2_PWM1_BIT] = i_pwm_out[1];
                p2_oe_next[`P2_PWM0_BIT] = 1'b1;
                p2_oe_next[`P2_PWM1_BIT] = 1'b1;
            end
        end
    end

    // Alternate sources pull low only; a one is left to the weak pull-up.
    always_comb begin
        p3_alt_drive = 8'h_00;
        p3_alt_level = 8'h_ff;
        p3_alt_drive[`P3_RXD_BIT] = i_uart_mode0_data_oe;
        p3_alt_level[`P3_RXD_BIT] = i_uart_mode0_data;
        p3_alt_drive[`P3_TXD_BIT] = 1'b1;
        p3_alt_level[`P3_TXD_BIT] = i_uart_txd;
        p3_alt_drive[`P3_IRQ1_BIT] = i_miso_oe;
        p3_alt_level[`P3_IRQ1_BIT] = i_miso;
        p3_alt_drive[`P3_WR_BIT] = 1'b1;
        p3_alt_level[`P3_WR_BIT] = i_ext_write_strobe_n;
        p3_alt_drive[`P3_RD_BIT] = 1'b1;
        p3_alt_level[`P3_RD_BIT] = i_ext_read_strobe_n;
        if (i_pwm_on_port_three) begin
            p3_alt_drive[`P3_IRQ1_BIT] = 1'b1;
            p3_alt_level[`P3_IRQ1_BIT] = i_pwm_out[1];
            p3_alt_drive[`P3_T0_BIT] = 1'b1;
            p3_alt_level[`P3_T0_BIT] = i_pwm_out[0];
        end
        p3_out_next = 8'h_00;
        // A zero latch holds the pin low whatever the peripheral does.
        p3_oe_next = ~latch_reg[3] | (latch_reg[3] & p3_alt_drive & ~p3_alt_level);
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_port_zero_out <= 8'h_00;
            o_port_zero_oe <= 8'h_00;
            o_port_two_out <= 8'h_00;
            o_port_two_oe <= 8'h_00;
            o_port_two_pullup <= 8'h_ff;
            o_port_three_out <= 8'h_00;
            o_port_three_oe <= 8'h_00;
            o_port_three_pullup <= 8'h_ff;
            o_port_one_digital_en <= 8'h_00;
        end else begin
            o_port_zero_out <= p0_out_next;
            o_port_zero_oe <= p0_oe_next;
            o_port_two_out <= p2_out_next;
            o_port_two_oe <= p2_oe_next;
            o_port_two_pullup <= i_ext_access ? 8'h_00 : 8'h_ff;
            o_port_three_out <= p3_out_next;
            o_port_three_oe <= p3_oe_next;
            o_port_three_pullup <= 8'h_ff;
            o_port_one_digital_en <= ~latch_reg[1];
        end
    end

    // ----------------------------------------
    // Decoded inputs to peripherals
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_timer2_count_input <= 1'b1;
            o_timer2_capture_trigger <= 1'b1;
            o_spi_slave_select_n <= 1'b1;
            o_uart_rxd <= 1'b1;
            o_external_irq_zero <= 1'b1;
            o_external_irq_one <= 1'b1;
            o_timer_zero_count_input <= 1'b1;
            o_timer_one_count_input <= 1'b1;
        end else begin
            o_timer2_count_input <= pin_sync2_reg[1][`P1_T2_BIT];
            o_timer2_capture_trigger <= pin_sync2_reg[1][`P1_TIMER2_CAPTURE_TRIGGER_BIT];
            o_spi_slave_select_n <= pin_sync2_reg[1][`P1_SS_BIT];
            o_uart_rxd <= pin_sync2_reg[3][`P3_RXD_BIT];
            o_external_irq_zero <= pin_sync2_reg[3][`P3_IRQ0_BIT];
            o_external_irq_one <= pin_sync2_reg[3][`P3_IRQ1_BIT];
            o_timer_zero_count_input <= pin_sync2_reg[3][`P3_T0_BIT];
            o_timer_one_count_input <= pin_sync2_reg[3][`P3_T1_BIT];
        end
    end

    // ----------------------------------------
    // Dedicated serial pins
    // ----------------------------------------
    glitch_filter u_sclk_filter (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_level(i_serial_clock_pin),
        .o_level(sclk_filt)
    );

    glitch_filter u_sdat_filter (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_level(i_serial_data_pin),
        .o_level(sdat_filt)
    );

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_serial_clock_pin_out <= 1'b0;
            o_serial_clock_pin_oe <= 1'b0;
            o_serial_clock_strong <= 1'b0;
            o_serial_data_pin_out <= 1'b0;
            o_serial_data_pin_oe <= 1'b0;
            o_serial_data_strong <= 1'b0;
            o_serial_clock_spi <= 1'b1;
            o_serial_data_spi <= 1'b1;
            o_serial_clock_twi <= 1'b1;
            o_serial_data_twi <= 1'b1;
        end else begin
            if (i_spi_mode_select) begin
                o_serial_clock_pin_out <= i_spi_clock;
                o_serial_clock_pin_oe <= i_spi_clock_oe;
                o_serial_clock_strong <= i_spi_clock_oe;
                o_serial_data_pin_out <= i_spi_data;
                o_serial_data_pin_oe <= i_spi_data_oe;
                o_serial_data_strong <= i_spi_data_oe;
            end else begin
                // Two-wire pins only sink; a high is left to the weak pull-up.
                o_serial_clock_pin_out <= 1'b0;
                o_serial_clock_strong <= 1'b0;
                o_serial_data_pin_out <= 1'b0;
                o_serial_data_strong <= 1'b0;
                if (i_twi_direct_en) begin
                    o_serial_clock_pin_oe <= ~i_twi_direct_clock;
                    o_serial_data_pin_oe <= ~i_twi_direct_data;
                end else begin
                    o_serial_clock_pin_oe <= i_twi_clock_low;
                    o_serial_data_pin_oe <= i_twi_data_low;
                end
            end
            o_serial_clock_spi <= sclk_sync_reg[1];
            o_serial_data_spi <= sdat_sync_reg[1];
            o_serial_clock_twi <= sclk_filt;
            o_serial_data_twi <= sdat_filt;
        end
    end
endmodule

// ==== tb/four_port_parallel_io_props.sv ====
// Assertions on the parallel port block and their bind.
`timescale 1ns/1ps
module four_port_parallel_io_props (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_latch_write,
    input wire logic i_rmw_bit,
    input wire logic [1:0] i_port_sel,
    input wire logic [7:0] i_write_data,
    input wire logic i_ext_access,
    input wire logic i_ext_data_space,
    input wire logic [7:0] i_ext_addr_data,
    input wire logic [7:0] i_ext_addr_high,
    input wire logic [7:0] i_ext_addr_mid,
    input wire logic i_ext_write_strobe_n,
    input wire logic i_pwm_on_port_two,
    input wire logic [1:0] i_pwm_out,
    input wire logic i_spi_mode_select,
    input wire logic [7:0] o_port_zero_out,
    input wire logic [7:0] o_port_zero_oe,
    input wire logic [7:0] o_port_one_digital_en,
    input wire logic [7:0] o_port_two_out,
    input wire logic [7:0] o_port_two_oe,
    input wire logic [7:0] o_port_three_oe,
    input wire logic o_serial_clock_strong,
    input wire logic o_serial_data_strong
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);
    // --------
    // Sequences and properties
    // --------
    // A write, then a cycle that leaves that latch alone.
    sequence s_wr(logic [1:0] s);
        i_latch_write && !i_rmw_bit && !i_ext_access && i_port_sel == s;
    endsequence
    sequence s_calm(logic [1:0] s);
        !i_ext_access && !((i_latch_write || i_rmw_bit) && i_port_sel == s);
    endsequence
    property p_p0_gp;
        s_wr(2'h0) ##1 s_calm(2'h0) |=> o_port_zero_oe == ~$past(i_write_data, 2) && o_port_zero_out == 8'h_00;
    endproperty
    a_p0_gp: assert property (p_p0_gp) else $error("p0 drive");
    property p_p0_ext;
        i_ext_access |=> o_port_zero_oe == 8'h_ff && o_port_zero_out == $past(i_ext_addr_data);
    endproperty
    a_p0_ext: assert property (p_p0_ext) else $error("p0 bus drive");
    property p_p0_force;
        i_ext_access ##1 s_calm(2'h0) |=> o_port_zero_oe == 8'h_00;
    endproperty
    a_p0_force: assert property (p_p0_force) else $error("p0 latch set");
    property p_p2_ext;
        i_ext_access |=> o_port_two_oe == 8'h_ff &&
            o_port_two_out == ($past(i_ext_data_space) ? $past(i_ext_addr_mid) : $past(i_ext_addr_high));
    endproperty
    a_p2_ext: assert property (p_p2_ext) else $error("p2 address");
    property p_p1_en;
        s_wr(2'h1) ##1 s_calm(2'h1) |=> o_port_one_digital_en == ~$past(i_write_data, 2);
    endproperty
    a_p1_en: assert property (p_p1_en) else $error("p1 input mode");
    property p_p3_alt;
        s_wr(2'h3) ##1 s_calm(2'h3) |=>
            o_port_three_oe[6] == (!$past(i_write_data[6], 2) || !$past(i_ext_write_strobe_n));
    endproperty
    a_p3_alt: assert property (p_p3_alt) else $error("p3 strobe drive");
    property p_p2_pwm;
        i_pwm_on_port_two && !i_ext_access |=> o_port_two_oe[7:6] == 2'h3 && o_port_two_out[7:6] == $past(i_pwm_out);
    endproperty
    a_p2_pwm: assert property (p_p2_pwm) else $error("p2 pwm");
    property p_ser_twi;
        !i_spi_mode_select [*2] |-> !o_serial_clock_strong && !o_serial_data_strong;
    endproperty
    a_ser_twi: assert property (p_ser_twi) else $error("strong pull-up in two-wire");
endmodule
bind four_port_parallel_io four_port_parallel_io_props props_u (.*);

// ==== tb/pin_model.sv ====
// Pin model of a port: drivers, pull-ups, floating lines.
`timescale 1ns/1ps
module pin_model (
    input wire logic i_clk,
    input wire logic [7:0] i_out,
    input wire logic [7:0] i_oe,
    input wire logic [7:0] i_pull,
    input wire logic [7:0] i_ext_en,
    input wire logic [7:0] i_ext_val,
    output logic [7:0] o_pin
);
    // A floating line toggles, so a read of it cannot match by luck.
    logic [7:0] float_reg = 8'h_55;
    always @(posedge i_clk) begin
        float_reg <= ~float_reg;
    end
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            if (i_oe[k]) begin
                o_pin[k] = i_out[k];
            end else if (i_ext_en[k]) begin
                o_pin[k] = i_ext_val[k];
            end else if (i_pull[k]) begin
                o_pin[k] = 1'b1;
            end else begin
                o_pin[k] = float_reg[k];
            end
        end
    end
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the parallel port block.
`timescale 1ns/1ps
module tb;
    logic i_clk, i_reset_n, i_latch_write, i_latch_read, i_pin_read, i_rmw_bit, i_bit_value, i_ext_access;
    logic i_ext_data_space, i_ext_write_strobe_n, i_ext_read_strobe_n, i_uart_txd, i_uart_mode0_data_oe;
    logic i_uart_mode0_data, i_miso_oe, i_miso, i_pwm_on_port_two, i_pwm_on_port_three, i_spi_mode_select;
    logic i_spi_clock_oe, i_spi_clock, i_spi_data_oe, i_spi_data, i_twi_clock_low, i_twi_data_low;
    logic i_twi_direct_en, i_twi_direct_clock, i_twi_direct_data, i_serial_clock_pin, i_serial_data_pin;
    logic o_timer2_count_input, o_timer2_capture_trigger, o_spi_slave_select_n, o_uart_rxd;
    logic o_external_irq_zero, o_external_irq_one, o_timer_zero_count_input, o_timer_one_count_input;
    logic o_serial_clock_pin_out, o_serial_clock_pin_oe, o_serial_clock_strong, o_serial_data_pin_out;
    logic o_serial_data_pin_oe, o_serial_data_strong, o_serial_clock_spi, o_serial_data_spi;
    logic o_serial_clock_twi, o_serial_data_twi, sck_x, sda_x;
    logic [2:0] i_bit_index;
    logic [1:0] i_port_sel, i_pwm_out;
    logic [7:0] i_write_data, i_ext_addr_data, i_ext_addr_high, i_ext_addr_mid, o_read_data, p0x, p1x, p3x, p3e;
    logic [7:0] i_port_zero_pin, i_port_one_pin, i_port_two_pin, i_port_three_pin, o_port_zero_out;
    logic [7:0] o_port_zero_oe, o_port_one_digital_en, o_port_two_out, o_port_two_oe, o_port_two_pullup;
    logic [7:0] o_port_three_out, o_port_three_oe, o_port_three_pullup;
    int failures, num_checks;
    four_port_parallel_io dut_u (.*);
    pin_model p0_u (.i_clk, .i_out(o_port_zero_out), .i_oe(o_port_zero_oe), .i_pull(8'h_00),
        .i_ext_en(8'h_ff), .i_ext_val(p0x), .o_pin(i_port_zero_pin));
    assign i_port_one_pin = p1x;
    pin_model p2_u (.i_clk, .i_out(o_port_two_out), .i_oe(o_port_two_oe), .i_pull(o_port_two_pullup),
        .i_ext_en(8'h_00), .i_ext_val(8'h_00), .o_pin(i_port_two_pin));
    pin_model p3_u (.i_clk, .i_out(o_port_three_out), .i_oe(o_port_three_oe), .i_pull(o_port_three_pullup),
        .i_ext_en(p3e), .i_ext_val(p3x), .o_pin(i_port_three_pin));
    // A released serial line reads the outside level.
    assign i_serial_clock_pin = o_serial_clock_pin_oe ? o_serial_clock_pin_out : sck_x;
    assign i_serial_data_pin = o_serial_data_pin_oe ? o_serial_data_pin_out : sda_x;
    // --------
    // Tasks
    // --------
    task automatic tk(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [1:0] s, input logic [7:0] d);
        i_port_sel = s;
        i_write_data = d;
        i_latch_write = 1'b1;
        tk(1);
        i_latch_write = 1'b0;
        tk(1);
    endtask
    task automatic rmw(input logic [1:0] s, input logic [2:0] b, input logic v);
        {i_port_sel, i_bit_index, i_bit_value, i_rmw_bit} = {s, b, v, 1'b1};
        tk(1);
        i_rmw_bit = 1'b0;
        tk(1);
    endtask
    task automatic rd(input logic [1:0] s, input logic pin, input logic [7:0] e);
        {i_port_sel, i_latch_read, i_pin_read} = {s, !pin, pin};
        tk(1);
        chk("read_data", e, o_read_data);
        {i_latch_read, i_pin_read} = 2'h0;
        tk(1);
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        failures++;
        complete_run();
    end
    // --------
    // Main sequence
    // --------
    initial begin
        {i_reset_n, i_latch_write, i_latch_read, i_pin_read, i_rmw_bit, i_bit_value, i_ext_access} = '0;
        {i_ext_data_space, i_uart_mode0_data_oe, i_miso_oe, i_pwm_on_port_two, i_pwm_on_port_three} = '0;
        {i_spi_mode_select, i_spi_clock_oe, i_spi_clock, i_spi_data_oe, i_spi_data, i_twi_clock_low} = '0;
        {i_twi_data_low, i_twi_direct_en, i_twi_direct_clock, i_twi_direct_data, i_bit_index, i_port_sel} = '0;
        {i_ext_write_strobe_n, i_ext_read_strobe_n, i_uart_txd, i_uart_mode0_data, i_miso, sck_x, sda_x} = '1;
        {i_write_data, i_ext_addr_data, i_ext_addr_high, i_ext_addr_mid, p3e, i_pwm_out} = '0;
        {p0x, p1x, p3x} = {8'h_ff, 8'h_23, 8'h_ff};
        tk(2);
        i_reset_n = 1'b1;
        tk(1);
        chk("p1_digital_en", 8'h_00, o_port_one_digital_en);
        chk("p3_pullup", 8'h_ff, o_port_three_pullup);
        for (int p = 0; p < 4; p++) begin
            rd(2'(p), 1'b0, 8'h_ff);
        end
        for (int p = 0; p < 4; p++) begin
            wr(2'(p), 8'h_5a);
            rd(2'(p), 1'b0, 8'h_5a);
        end
        chk("p0_oe", 8'h_a5, o_port_zero_oe);
        chk("p1_digital_en", 8'h_a5, o_port_one_digital_en);
        chk("p2_oe", 8'h_a5, o_port_two_oe);
        chk("p3_oe", 8'h_a5, o_port_three_oe);
        for (int p = 0; p < 4; p++) begin
            rd(2'(p), 1'b1, (p == 1) ? 8'h_23 : 8'h_5a);
        end
        // An outside device pulls a high port three pin low.
        {p3e, p3x} = {8'h_02, 8'h_00};
        tk(4);
        rd(2'h3, 1'b1, 8'h_58);
        rmw(2'h3, 3'h7, 1'b1);
        rd(2'h3, 1'b0, 8'h_da);
        wr(2'h2, 8'h_3c);
        {i_ext_addr_data, i_ext_addr_high, i_ext_addr_mid, i_ext_access} = {8'h_96, 8'h_12, 8'h_34, 1'b1};
        tk(2);
        chk("p0_out", 8'h_96, o_port_zero_out);
        chk("p0_oe", 8'h_ff, o_port_zero_oe);
        chk("p2_out", 8'h_12, o_port_two_out);
        chk("p2_pullup", 8'h_00, o_port_two_pullup);
        i_ext_data_space = 1'b1;
        tk(2);
        chk("p2_out", 8'h_34, o_port_two_out);
        wr(2'h0, 8'h_00);
        i_ext_access = 1'b0;
        tk(2);
        rd(2'h0, 1'b0, 8'h_ff);
        rd(2'h2, 1'b0, 8'h_3c);
        chk("p0_oe", 8'h_00, o_port_zero_oe);
        chk("p2_oe", 8'h_c3, o_port_two_oe);
        wr(2'h3, 8'h_ff);
        {i_pwm_on_port_two, i_pwm_on_port_three} = 2'h3;
        for (int k = 1; k < 3; k++) begin
            i_pwm_out = 2'(k);
            tk(2);
            chk("p2_pwm", {i_pwm_out, 6'h0}, o_port_two_out & 8'h_c0);
            chk("p3_pwm_oe", {3'h0, ~i_pwm_out[0], ~i_pwm_out[1], 3'h0}, o_port_three_oe & 8'h_18);
        end
        {i_pwm_on_port_two, i_pwm_on_port_three, p3e} = {2'h0, 8'h_00};
        {i_uart_mode0_data_oe, i_uart_mode0_data, i_uart_txd, i_miso_oe, i_miso} = 5'h12;
        {i_ext_write_strobe_n, i_ext_read_strobe_n} = 2'h0;
        tk(2);
        chk("p3_alt_oe", 8'h_cb, o_port_three_oe);
        {i_uart_mode0_data, i_uart_txd, i_miso, i_ext_write_strobe_n, i_ext_read_strobe_n} = 5'h1f;
        wr(2'h3, 8'h_0f);
        tk(1);
        chk("p3_alt_oe", 8'h_f0, o_port_three_oe);
        wr(2'h3, 8'h_ff);
        p3e = 8'h_ff;
        for (int k = 0; k < 2; k++) begin
            {p1x, p3x} = {2{k ? 8'h_d2 : 8'h_2d}};
            tk(5);
            chk("p1_alt", {5'h0, p1x[5], p1x[1], p1x[0]}, {5'h0, o_spi_slave_select_n,
                o_timer2_capture_trigger, o_timer2_count_input});
            chk("p3_alt", {3'h0, p3x[5], p3x[4], p3x[3], p3x[2], p3x[0]}, {3'h0, o_timer_one_count_input,
                o_timer_zero_count_input, o_external_irq_one, o_external_irq_zero, o_uart_rxd});
        end
        {i_spi_mode_select, i_spi_clock_oe, i_spi_clock} = 3'h7;
        tk(2);
        chk("sck_spi", 8'h_03, {6'h0, o_serial_clock_strong, o_serial_clock_pin_out});
        {i_spi_mode_select, i_twi_clock_low} = 2'h1;
        tk(2);
        chk("sck_twi", 8'h_02, {5'h0, o_serial_clock_strong, o_serial_clock_pin_oe, o_serial_clock_pin_out});
        {i_twi_direct_en, i_twi_direct_clock, i_twi_direct_data} = 3'h5;
        tk(2);
        chk("ser_direct", 8'h_02, {6'h0, o_serial_clock_pin_oe, o_serial_data_pin_oe});
        {i_twi_direct_en, i_twi_clock_low} = 2'h0;
        tk(20);
        // A five-cycle pulse is rejected; a held level passes.
        {sck_x, sda_x} = 2'h0;
        tk(5);
        {sck_x, sda_x} = 2'h3;
        tk(15);
        chk("twi_glitch", 8'h_03, {6'h0, o_serial_clock_twi, o_serial_data_twi});
        {sck_x, sda_x} = 2'h0;
        tk(15);
        chk("twi_level", 8'h_00, {5'h0, o_serial_clock_twi, o_serial_data_twi, o_serial_clock_spi});
        complete_run();
    end
endmodule
